// File: common/adcs_pkg.sv
// Package for the converter sequencer: register map, fields, counts and types
`default_nettype none

package adcs_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address is four times the index
    localparam logic [15:0] ADCS_MODE_IDX = 16'hFFC4;
    localparam logic [15:0] ADCS_RESULT_IDX = 16'hFFC5;
    localparam logic [15:0] ADCS_START_IDX = 16'hFFC6;
    localparam logic [15:0] ADCS_IRQ_REQ_IDX = 16'hFFC8;
    localparam logic [15:0] ADCS_IRQ_EN_IDX = 16'hFFC9;
    localparam logic [15:0] ADCS_PORT_MODE_IDX = 16'hFFCA;
    localparam logic [15:0] ADCS_EDGE_SEL_IDX = 16'hFFCB;
    localparam int ADCS_ADDR_W = 18;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int ADCS_SPEED_BIT = 7;
    localparam int ADCS_TRIG_EN_BIT = 6;
    localparam int ADCS_CHAN_LSB = 0;
    localparam int ADCS_START_BIT = 7;
    localparam int ADCS_DONE_BIT = 0;
    localparam int ADCS_IRQ_EN_BIT = 0;
    localparam int ADCS_PIN_FUNC_BIT = 0;
    localparam int ADCS_EDGE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // Read-as-one reserved bits and reset values
    localparam logic [7:0] ADCS_MODE_RSVD = 8'h30;
    localparam logic [7:0] ADCS_START_RSVD = 8'h7F;
    localparam logic [3:0] ADCS_CHAN_RST = 4'h0;
    localparam logic [7:0] ADCS_SAR_MSB = 8'h80;

    ////////////////////////////////////////////////////////////////////////////////
    // Conversion periods in system clocks and approximation steps
    localparam logic [5:0] ADCS_CONV_CLKS_SLOW = 6'd62;
    localparam logic [5:0] ADCS_CONV_CLKS_FAST = 6'd31;
    localparam logic [3:0] ADCS_STEPS = 4'd8;
    localparam int ADCS_CHANNELS = 12;

    ////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        ADCS_IDLE = 2'b01,
        ADCS_CONV = 2'b10
    } adcs_phase_type;

    typedef struct packed {
        logic sel;
        logic write;
        logic [ADCS_ADDR_W-1:0] addr;
    } adcs_aphase_type;

    typedef struct packed {
        adcs_phase_type phase;
        logic speed;
        logic trig_en;
        logic [3:0] chan;
        logic start_flag;
        logic done_flag;
        logic irq_en;
        logic pin_func;
        logic edge_sel;
        logic [7:0] result;
        logic [5:0] cnt;
        logic [2:0] step;
        logic trig_prev;
        adcs_aphase_type ap;
        logic [31:0] hrdata;
        logic [ADCS_CHANNELS-1:0] chan_en;
        logic irq;
        logic ready;
    } adcs_state_type;

endpackage

`default_nettype wire

// File: src/adcs_sync.sv
// Two-flop synchroniser for pin-level inputs
`default_nettype none

module adcs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } adcs_sync_state_type;

    adcs_sync_state_type r;
    adcs_sync_state_type next_r;

    always_comb begin
        next_r.s1 = async_in;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign sync_out = r.s2;

endmodule

`default_nettype wire

// File: src/adcs_sar.sv
// Successive-approximation trial register, one bit decided per step
`default_nettype none

module adcs_sar (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic clear_in,
    input wire logic decide_in,
    input wire logic comp_high_in,
    output logic [7:0] trial_out,
    output logic [7:0] final_out
);

    typedef struct packed {
        logic [7:0] trial;
        logic [7:0] bitpos;
    } adcs_sar_state_type;

    adcs_sar_state_type r;
    adcs_sar_state_type next_r;
    logic [7:0] kept;

    // Drop the bit under test when the input lies below the trial level
    always_comb begin
        next_r = r;
        kept = comp_high_in ? r.trial : (r.trial & ~r.bitpos);
        if (clear_in) begin
            next_r.trial = adcs_pkg::ADCS_SAR_MSB;
            next_r.bitpos = adcs_pkg::ADCS_SAR_MSB;
        end else if (decide_in) begin
            next_r.bitpos = r.bitpos >> 1;
            next_r.trial = kept | (r.bitpos >> 1);
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            r <= '{trial: adcs_pkg::ADCS_SAR_MSB, bitpos: adcs_pkg::ADCS_SAR_MSB};
        end else begin
            r <= next_r;
        end
    end

    assign trial_out = r.trial;
    assign final_out = kept;

endmodule

`default_nettype wire

// File: src/adcs_top.sv
// Conversion sequencer for an 8-bit successive-approximation converter
//
// Operation
// - Convert by successive approximation; each result is an 8-bit value.
// - Writing 1 to start flag begins; flag reads 1 throughout, self-clears.
// - Every completed conversion sets the done request flag.
// - Interrupt asserted only while done flag and its enable are both 1.
// - Trigger pin starts only with pin-function bit and trigger enable set.
// - Selected trigger edge sets start flag and begins conversion.
// - At end: result written, done set, start cleared together; back to idle.
// - Channel code 0101 routes analog input one to the converter.
// - Setting start again after completion launches a fresh conversion.
// - Writing 0 to start flag stops a conversion in progress.
// - Speed bit 0 gives 62 clocks per conversion, 1 gives 31.
// - Channel code 00xx selects none; 01xx,10xx,11xx select 0-3,4-7,8-11.
// - Result holds until next conversion; reset leaves it untouched.
`default_nettype none

module adcs_top (
    input wire logic core_clk_in,
    input wire logic srst_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic trigger_pin_in,
    input wire logic comp_high_in,
    output logic [7:0] dac_code_out,
    output logic [adcs_pkg::ADCS_CHANNELS-1:0] channel_enable_out,
    output logic converting_out,
    output logic irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Byte addresses
    localparam logic [17:0] MODE_A = {adcs_pkg::ADCS_MODE_IDX, 2'b00};
    localparam logic [17:0] RESULT_A = {adcs_pkg::ADCS_RESULT_IDX, 2'b00};
    localparam logic [17:0] START_A = {adcs_pkg::ADCS_START_IDX, 2'b00};
    localparam logic [17:0] IRQ_REQ_A = {adcs_pkg::ADCS_IRQ_REQ_IDX, 2'b00};
    localparam logic [17:0] IRQ_EN_A = {adcs_pkg::ADCS_IRQ_EN_IDX, 2'b00};
    localparam logic [17:0] PORT_MODE_A = {adcs_pkg::ADCS_PORT_MODE_IDX, 2'b00};
    localparam logic [17:0] EDGE_SEL_A = {adcs_pkg::ADCS_EDGE_SEL_IDX, 2'b00};

    localparam adcs_pkg::adcs_state_type STATE_RST = '{
        phase: adcs_pkg::ADCS_IDLE,
        speed: 1'b0,
        trig_en: 1'b0,
        chan: adcs_pkg::ADCS_CHAN_RST,
        start_flag: 1'b0,
        done_flag: 1'b0,
        irq_en: 1'b0,
        pin_func: 1'b0,
        edge_sel: 1'b0,
        result: 8'h00,
        cnt: 6'h00,
        step: 3'h0,
        trig_prev: 1'b0,
        ap: '{sel: 1'b0, write: 1'b0, addr: 18'h00000},
        hrdata: 32'h00000000,
        chan_en: 12'h000,
        irq: 1'b0,
        ready: 1'b1
    };

    adcs_pkg::adcs_state_type r;
    adcs_pkg::adcs_state_type next_r;
    adcs_pkg::adcs_state_type rst_val;

    logic trig_s;
    logic comp_s;
    logic [7:0] sar_trial;
    logic [7:0] sar_final;
    logic sar_clear;
    logic sar_decide;
    logic [5:0] period;
    logic [9:0] done_scaled;
    logic [9:0] step_edge;
    logic last_cycle;
    logic step_due;
    logic wr;
    logic [7:0] wd;
    logic sw_start;
    logic sw_stop;
    logic trig_edge;
    logic ext_start;
    logic [3:0] chan_idx;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and approximation register
    adcs_sync #(.WIDTH(1)) trig_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .async_in(trigger_pin_in),
        .sync_out(trig_s)
    );

    adcs_sync #(.WIDTH(1)) comp_sync (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .async_in(comp_high_in),
        .sync_out(comp_s)
    );

    adcs_sar sar (
        .core_clk_in(core_clk_in),
        .srst_in(srst_in),
        .clear_in(sar_clear),
        .decide_in(sar_decide),
        .comp_high_in(comp_s),
        .trial_out(sar_trial),
        .final_out(sar_final)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Register read view
    function automatic logic [31:0] read_reg(input logic [17:0] a,
                                             input adcs_pkg::adcs_state_type s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            MODE_A: begin
                v = adcs_pkg::ADCS_MODE_RSVD;
                v[adcs_pkg::ADCS_SPEED_BIT] = s.speed;
                v[adcs_pkg::ADCS_TRIG_EN_BIT] = s.trig_en;
                v[adcs_pkg::ADCS_CHAN_LSB +: 4] = s.chan;
            end
            RESULT_A: begin
                v = s.result;
            end
            START_A: begin
                v = adcs_pkg::ADCS_START_RSVD;
                v[adcs_pkg::ADCS_START_BIT] = s.start_flag;
            end
            IRQ_REQ_A: begin
                v[adcs_pkg::ADCS_DONE_BIT] = s.done_flag;
            end
            IRQ_EN_A: begin
                v[adcs_pkg::ADCS_IRQ_EN_BIT] = s.irq_en;
            end
            PORT_MODE_A: begin
                v[adcs_pkg::ADCS_PIN_FUNC_BIT] = s.pin_func;
            end
            EDGE_SEL_A: begin
                v[adcs_pkg::ADCS_EDGE_BIT] = s.edge_sel;
            end
            default: begin
                v = 8'h00;
            end
        endcase
        return {24'h000000, v};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Step timing: step k ends at the first count where (cnt+1)*8 >= (k+1)*period
    always_comb begin
        period = r.speed ? adcs_pkg::ADCS_CONV_CLKS_FAST
                         : adcs_pkg::ADCS_CONV_CLKS_SLOW;
        done_scaled = ({4'h0, r.cnt} + 10'd1) << 3;
        step_edge = ({7'h000, r.step} + 10'd1) * {4'h0, period};
        step_due = done_scaled >= step_edge;
        last_cycle = r.cnt == (period - 6'd1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode, trigger detection and sequencing
    always_comb begin
        next_r = r;
        sar_clear = 1'b0;
        sar_decide = 1'b0;
        next_r.ready = 1'b1;

        // Address phase; read data is captured here for the data phase
        if (hsel_in && htrans_in[1] && hready_in) begin
            next_r.ap.sel = 1'b1;
            next_r.ap.write = hwrite_in;
            next_r.ap.addr = haddr_in[17:0];
            next_r.hrdata = hwrite_in ? 32'h00000000 : read_reg(haddr_in[17:0], r);
        end else begin
            next_r.ap.sel = 1'b0;
        end

        // Data phase writes
        wr = r.ap.sel && r.ap.write;
        wd = hwdata_in[7:0];
        sw_start = wr && (r.ap.addr == START_A) && wd[adcs_pkg::ADCS_START_BIT];
        sw_stop = wr && (r.ap.addr == START_A) && !wd[adcs_pkg::ADCS_START_BIT];
        if (wr && (r.ap.addr == MODE_A)) begin
            next_r.speed = wd[adcs_pkg::ADCS_SPEED_BIT];
            next_r.trig_en = wd[adcs_pkg::ADCS_TRIG_EN_BIT];
            next_r.chan = wd[adcs_pkg::ADCS_CHAN_LSB +: 4];
        end
        if (wr && (r.ap.addr == IRQ_EN_A)) begin
            next_r.irq_en = wd[adcs_pkg::ADCS_IRQ_EN_BIT];
        end
        if (wr && (r.ap.addr == PORT_MODE_A)) begin
            next_r.pin_func = wd[adcs_pkg::ADCS_PIN_FUNC_BIT];
        end
        if (wr && (r.ap.addr == EDGE_SEL_A)) begin
            next_r.edge_sel = wd[adcs_pkg::ADCS_EDGE_BIT];
        end
        if (wr && (r.ap.addr == IRQ_REQ_A) && wd[adcs_pkg::ADCS_DONE_BIT]) begin
            next_r.done_flag = 1'b0;
        end

        // Edge select 1 picks rising, 0 falling
        next_r.trig_prev = trig_s;
        trig_edge = r.edge_sel ? (trig_s && !r.trig_prev) : (!trig_s && r.trig_prev);
        ext_start = r.pin_func && r.trig_en && trig_edge;

        case (r.phase)
            adcs_pkg::ADCS_IDLE: begin
                if (sw_start || ext_start) begin
                    next_r.start_flag = 1'b1;
                    next_r.phase = adcs_pkg::ADCS_CONV;
                    next_r.cnt = 6'h00;
                    next_r.step = 3'h0;
                    sar_clear = 1'b1;
                end
            end
            adcs_pkg::ADCS_CONV: begin
                if (sw_stop) begin
                    next_r.start_flag = 1'b0;
                    next_r.phase = adcs_pkg::ADCS_IDLE;
                end else begin
                    next_r.cnt = r.cnt + 6'd1;
                    if (step_due) begin
                        sar_decide = 1'b1;
                        next_r.step = r.step + 3'd1;
                    end
                    if (last_cycle) begin
                        next_r.result = sar_final;
                        next_r.done_flag = 1'b1;
                        next_r.start_flag = 1'b0;
                        next_r.phase = adcs_pkg::ADCS_IDLE;
                    end
                end
            end
            default: begin
                next_r.phase = adcs_pkg::ADCS_IDLE;
                next_r.start_flag = 1'b0;
            end
        endcase

        // Channel routing only while converting
        chan_idx = {next_r.chan[3:2] - 2'd1, next_r.chan[1:0]};
        if ((next_r.phase == adcs_pkg::ADCS_CONV) && (next_r.chan[3:2] != 2'b00)) begin
            next_r.chan_en = 12'h001 << chan_idx;
        end else begin
            next_r.chan_en = 12'h000;
        end

        next_r.irq = next_r.done_flag && next_r.irq_en;

        rst_val = STATE_RST;
        rst_val.result = r.result;
    end

    always_ff @(posedge core_clk_in) begin
        if (srst_in) begin
            r <= rst_val;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign hrdata_out = r.hrdata;
    assign hreadyout_out = r.ready;
    assign hresp_out = 1'b0;
    assign dac_code_out = sar_trial;
    assign channel_enable_out = r.chan_en;
    assign converting_out = r.start_flag;
    assign irq_out = r.irq;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (srst_in);

    conv_end_a: assert property (
        (r.phase == adcs_pkg::ADCS_CONV && last_cycle && !sw_stop)
        |=> (!r.start_flag && r.done_flag && r.phase == adcs_pkg::ADCS_IDLE))
        else $error("conversion end did not set done and clear start");

    done_cause_a: assert property (
        $rose(r.done_flag) |-> $past(r.cnt) == ($past(r.speed) ? 6'd30 : 6'd61))
        else $error("done flag rose away from period end");

    irq_gate_a: assert property (
        irq_out |-> (r.done_flag && r.irq_en))
        else $error("interrupt without done flag and enable");

    busy_flag_a: assert property (
        (r.phase == adcs_pkg::ADCS_CONV) |-> converting_out)
        else $error("start flag low during conversion");

    stop_a: assert property (
        (r.phase == adcs_pkg::ADCS_CONV && sw_stop)
        |=> (r.phase == adcs_pkg::ADCS_IDLE && !r.start_flag && $stable(r.result)))
        else $error("stop write did not halt conversion");

    trig_gate_a: assert property (
        (r.phase == adcs_pkg::ADCS_IDLE && !(r.pin_func && r.trig_en) && !sw_start)
        |=> r.phase == adcs_pkg::ADCS_IDLE)
        else $error("conversion started without enabled trigger");

    trig_start_a: assert property (
        (r.phase == adcs_pkg::ADCS_IDLE && ext_start)
        |=> (r.start_flag && r.phase == adcs_pkg::ADCS_CONV && r.cnt == 6'd0))
        else $error("trigger edge did not start conversion");

    restart_a: assert property (
        (r.phase == adcs_pkg::ADCS_IDLE && sw_start)
        |=> (r.phase == adcs_pkg::ADCS_CONV && sar_trial == 8'h80))
        else $error("start write did not launch conversion");

    result_hold_a: assert property (
        (r.phase == adcs_pkg::ADCS_IDLE) |=> $stable(r.result))
        else $error("result changed while idle");

    chan_one_a: assert property (
        (next_r.phase == adcs_pkg::ADCS_CONV && next_r.chan == 4'h5)
        |=> channel_enable_out == 12'h002)
        else $error("code 0101 did not route input one");

    chan_none_a: assert property (
        (r.chan[3:2] == 2'b00) |-> channel_enable_out == 12'h000)
        else $error("channel routed for a none code");

    step_count_a: assert property (
        (r.phase == adcs_pkg::ADCS_CONV && last_cycle && !sw_stop) |-> r.step == 3'd7)
        else $error("eight steps not done at period end");

    slow_done_c: cover property (
        (r.phase == adcs_pkg::ADCS_CONV && last_cycle && !r.speed && !sw_stop));
    fast_done_c: cover property (
        (r.phase == adcs_pkg::ADCS_CONV && last_cycle && r.speed && !sw_stop));
    ext_start_c: cover property (r.phase == adcs_pkg::ADCS_IDLE && ext_start);
    stop_c: cover property (r.phase == adcs_pkg::ADCS_CONV && sw_stop);

endmodule

`default_nettype wire

// File: verif/adcs_front_model.sv
// Comparator front end and external trigger source facing the sequencer
`default_nettype none

module adcs_front_model (
    input wire logic core_clk_in,
    input wire logic [7:0] dac_code_in,
    input wire logic [adcs_pkg::ADCS_CHANNELS-1:0] channel_enable_in,
    input wire logic trig_level_in,
    output logic comp_high_out,
    output logic trigger_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] level;
    logic wander = 1'b0;

    // Channel k carries a fixed level of 11h times (k + 1)
    always_comb begin
        level = 8'h00;
        for (int k = 0; k < adcs_pkg::ADCS_CHANNELS; k++) begin
            if (channel_enable_in[k]) begin
                level = 8'h11 * 8'(k + 1);
            end
        end
    end

    // An unrouted comparator input floats, so its answer wanders
    always @(posedge core_clk_in) begin
        wander <= ~wander;
        trigger_pin_out <= trig_level_in;
    end

    assign comp_high_out = (channel_enable_in == '0) ? wander : (level >= dac_code_in);

endmodule

`default_nettype wire

// File: verif/adcs_top_bench.sv
// Self-checking bench for the converter sequencer
`default_nettype none

module adcs_top_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic trig_level = 1'b0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic comp_high;
    logic trig_pin;
    logic [7:0] dac;
    logic [11:0] chan_en;
    logic converting;
    logic irq;
    logic [31:0] rd;
    int n_fail = 0;
    int comparisons = 0;

    adcs_top i_dut (
        .core_clk_in(core_clk), .srst_in(srst), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .trigger_pin_in(trig_pin), .comp_high_in(comp_high), .dac_code_out(dac),
        .channel_enable_out(chan_en), .converting_out(converting), .irq_out(irq)
    );

    adcs_front_model i_front (
        .core_clk_in(core_clk), .dac_code_in(dac), .channel_enable_in(chan_en),
        .trig_level_in(trig_level), .comp_high_out(comp_high), .trigger_pin_out(trig_pin)
    );

    initial begin
        forever #20 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic ready_edge();
        do begin
            @(posedge core_clk);
        end while (hready !== 1'b1);
        chk({30'h0, hresp, hready}, 32'h1, "bus answer");
    endtask

    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        haddr <= {14'h0, idx, 2'b00};
        hwrite <= w;
        htrans <= 2'b10;
        ready_edge();
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        ready_edge();
        rd = hrdata;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp}, "register");
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (converting === 1'b1 && n < 100) begin
            @(posedge core_clk);
            n++;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        rdchk(adcs_pkg::ADCS_MODE_IDX, 8'h30);
        rdchk(adcs_pkg::ADCS_START_IDX, 8'h7F);
        rdchk(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h00);
        wr(adcs_pkg::ADCS_MODE_IDX, 8'hC5);
        rdchk(adcs_pkg::ADCS_MODE_IDX, 8'hF5);
        wr(16'hFFD0, 8'hFF);
        rdchk(16'hFFD0, 8'h00);
    endtask

    task automatic sw_conv(input logic [7:0] mode, input logic [11:0] route,
                           input logic [7:0] res);
        int n;
        n = 0;
        wr(adcs_pkg::ADCS_MODE_IDX, mode);
        wr(adcs_pkg::ADCS_START_IDX, 8'h80);
        while (converting !== 1'b1 && n < 4) begin
            @(posedge core_clk);
            n++;
        end
        chk({20'h0, chan_en}, {20'h0, route}, "route");
        chk({24'h0, dac}, {24'h0, adcs_pkg::ADCS_SAR_MSB}, "first trial");
        rdchk(adcs_pkg::ADCS_START_IDX, 8'hFF);
        n = 3;
        do begin
            @(posedge core_clk);
            n++;
        end while (converting === 1'b1 && n < 100);
        chk(32'(n - 1), mode[7] ? 32'h1F : 32'h3E, "period");
        rdchk(adcs_pkg::ADCS_RESULT_IDX, res);
        rdchk(adcs_pkg::ADCS_START_IDX, 8'h7F);
        rdchk(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h01);
    endtask

    task automatic irq_chk(input logic exp);
        repeat (2) @(posedge core_clk);
        chk({31'h0, irq}, {31'h0, exp}, "irq");
    endtask

    task automatic t_conv_irq();
        wr(adcs_pkg::ADCS_IRQ_EN_IDX, 8'h01);
        sw_conv(8'h05, 12'h002, 8'h22);
        irq_chk(1'b1);
        wr(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h01);
        irq_chk(1'b0);
        wr(adcs_pkg::ADCS_IRQ_EN_IDX, 8'h00);
        sw_conv(8'h8D, 12'h200, 8'hAA);
        irq_chk(1'b0);
        wr(adcs_pkg::ADCS_IRQ_EN_IDX, 8'h01);
        irq_chk(1'b1);
        wr(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h01);
        irq_chk(1'b0);
    endtask

    task automatic t_channels_stop();
        for (int c = 0; c < 16; c++) begin
            wr(adcs_pkg::ADCS_MODE_IDX, {4'h0, 4'(c)});
            wr(adcs_pkg::ADCS_START_IDX, 8'h80);
            repeat (3) @(posedge core_clk);
            chk({20'h0, chan_en}, c < 4 ? 32'h0 : 32'h1 << (c - 4), "code");
            wr(adcs_pkg::ADCS_START_IDX, 8'h00);
            repeat (2) @(posedge core_clk);
            chk({31'h0, converting}, 32'h0, "stop");
        end
        rdchk(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h00);
        rdchk(adcs_pkg::ADCS_RESULT_IDX, 8'hAA);
    endtask

    task automatic trig_to(input logic lvl, input logic exp);
        trig_level <= lvl;
        repeat (8) @(posedge core_clk);
        chk({31'h0, converting}, {31'h0, exp}, "trigger");
        wait_idle();
    endtask

    task automatic t_trigger();
        wr(adcs_pkg::ADCS_EDGE_SEL_IDX, 8'h01);
        for (int i = 0; i < 4; i++) begin
            wr(adcs_pkg::ADCS_PORT_MODE_IDX, {7'h0, i[0]});
            wr(adcs_pkg::ADCS_MODE_IDX, {1'b1, i[1], 6'h05});
            trig_to(1'b1, i == 3);
            trig_to(1'b0, 1'b0);
        end
        wr(adcs_pkg::ADCS_EDGE_SEL_IDX, 8'h00);
        trig_to(1'b1, 1'b0);
        trig_to(1'b0, 1'b1);
        rdchk(adcs_pkg::ADCS_RESULT_IDX, 8'h22);
        rdchk(adcs_pkg::ADCS_IRQ_REQ_IDX, 8'h01);
    endtask

    task automatic t_result_kept();
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        rdchk(adcs_pkg::ADCS_RESULT_IDX, 8'h22);
        rdchk(adcs_pkg::ADCS_MODE_IDX, 8'h30);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        t_reset_values();
        t_conv_irq();
        t_channels_stop();
        t_trigger();
        t_result_kept();
        wrap_up();
    end

    initial begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        $display("mismatch at %0t: run did not finish", $time);
        wrap_up();
    end

endmodule

`default_nettype wire
